// [logic/dasc_pkg.sv]
// dasc_pkg: constants for the dual-channel converter serial and power-down control
// assumes: ref_clk at 200 MHz; serial clock and conversion start arrive from a host
package dasc_pkg;
  localparam int unsigned RES_BITS     = 14;
  localparam int unsigned WORD_W       = 2 * RES_BITS;
  localparam int unsigned LOCKOUT_EDGES = 32;
  localparam int unsigned FIRST_EDGE   = 3;
  localparam int unsigned GAP_EDGES    = 2;
  localparam int unsigned NAP_STARTS   = 2;
  localparam int unsigned SLEEP_STARTS = 4;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam logic [RES_BITS-1:0] CODE_MAX = {RES_BITS{1'b1}};
  localparam logic [RES_BITS-1:0] CODE_MIN = {RES_BITS{1'b0}};
  localparam logic [5:0] CNT_RST       = 6'h00;
  localparam logic [2:0] STARTS_RST    = 3'h0;
  typedef enum logic [2:0] {
    DASC_ACTIVE = 3'b001,
    DASC_NAP    = 3'b010,
    DASC_SLEEP  = 3'b100
  } dasc_pwr_e;
endpackage

// [logic/dasc_fifo.sv]
// dasc_fifo: small synchronous fifo for sampled channel pairs
// assumes: one clock, active-low synchronous-released reset
`timescale 1ns/1ps
module dasc_fifo #(
  parameter int unsigned WIDTH = 28,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,     // clock
  input  wire logic             rst_n,   // reset, active low
  input  wire logic [WIDTH-1:0] in_data, // write data
  input  wire logic             in_valid, // write request
  output logic                  in_ready, // not full
  output logic [WIDTH-1:0]      out_data, // head word
  output logic                  out_valid, // not empty
  input  wire logic             out_ready  // pop
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic             push;
  logic             pop;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
  assign out_valid = wr_r != rd_r;
  assign out_data  = mem[rd_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

// [logic/dasc_top.sv]
// dasc_top: conversion start, serial output and nap/sleep sequencing
// assumes: serial clock and start are async pins; analog front end supplies sampled level per channel
`timescale 1ns/1ps
module dasc_top (
  input  wire logic                              ref_clk,             // 200 MHz clock
  input  wire logic                              arst_n,              // async reset, active low
  input  wire logic                              serial_clk,          // serial clock pin from host
  input  wire logic                              conversion_start,    // conversion start pin
  input  wire logic [dasc_pkg::RES_BITS:0]       channel_zero_positive, // ch0 difference, msb set = over range
  input  wire logic                              channel_zero_neg,    // ch0 difference below zero
  input  wire logic [dasc_pkg::RES_BITS:0]       channel_one_positive, // ch1 difference, msb set = over range
  input  wire logic                              channel_one_neg,     // ch1 difference below zero
  output logic                                   sdo_o,               // serial data out
  output logic                                   sdo_oe,              // serial data drive enable
  output logic                                   ref_on,              // internal reference powered
  output logic                                   nap_o,               // nap state
  output logic                                   sleep_o,             // sleep state
  output logic                                   overflow_o           // a sample was dropped, fifo full
);
  localparam int unsigned W  = dasc_pkg::RES_BITS;
  localparam logic [5:0] LOCK = 6'(dasc_pkg::LOCKOUT_EDGES);
  localparam logic [5:0] W0S  = 6'(dasc_pkg::FIRST_EDGE);
  localparam logic [5:0] W1S  = 6'(dasc_pkg::FIRST_EDGE + dasc_pkg::RES_BITS + dasc_pkg::GAP_EDGES);

  logic       rst_s1_r, rst_n_r;
  logic [2:0] sck_sync_r, cnv_sync_r;
  logic       sck_rise, cnv_rise;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // stage 0 feeds only stage 1; edges found between stages 1 and 2
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sck_sync_r <= 3'h0;
      cnv_sync_r <= 3'h0;
    end else begin
      sck_sync_r <= {sck_sync_r[1:0], serial_clk};
      cnv_sync_r <= {cnv_sync_r[1:0], conversion_start};
    end
  end
  assign sck_rise = sck_sync_r[1] && !sck_sync_r[2];
  assign cnv_rise = cnv_sync_r[1] && !cnv_sync_r[2];

  // clamp each channel to the code range
  function automatic logic [W-1:0] clamp(input logic [W:0] v, input logic neg);
    logic [W-1:0] r;
    r = v[W-1:0];
    if (neg) begin
      r = dasc_pkg::CODE_MIN;
    end else if (v[W]) begin
      r = dasc_pkg::CODE_MAX;
    end
    return r;
  endfunction

  // power state and start counting
  typedef dasc_pkg::dasc_pwr_e dasc_pwr_e_t;
  dasc_pwr_e_t pwr_r;
  logic [2:0] starts_r;
  logic       lock_r;
  logic [5:0] edge_r;
  logic       accept;

  assign accept = cnv_rise && !lock_r && (pwr_r == dasc_pkg::DASC_ACTIVE);

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      starts_r <= dasc_pkg::STARTS_RST;
    end else if (sck_rise) begin
      starts_r <= dasc_pkg::STARTS_RST;
    end else if (cnv_rise && starts_r != 3'(dasc_pkg::SLEEP_STARTS)) begin
      starts_r <= starts_r + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pwr_r <= dasc_pkg::DASC_ACTIVE;
    end else begin
      unique case (pwr_r)
        dasc_pkg::DASC_ACTIVE: begin
          if (cnv_rise && !sck_rise && starts_r == 3'(dasc_pkg::NAP_STARTS - 1)) begin
            pwr_r <= dasc_pkg::DASC_NAP;
          end
        end
        dasc_pkg::DASC_NAP: begin
          if (sck_rise) begin
            pwr_r <= dasc_pkg::DASC_ACTIVE;
          end else if (cnv_rise && starts_r == 3'(dasc_pkg::SLEEP_STARTS - 1)) begin
            pwr_r <= dasc_pkg::DASC_SLEEP;
          end
        end
        dasc_pkg::DASC_SLEEP: begin
          if (cnv_rise && !sck_rise && starts_r == 3'(dasc_pkg::NAP_STARTS - 1)) begin
            pwr_r <= dasc_pkg::DASC_NAP;
          end
        end
        default: pwr_r <= dasc_pkg::DASC_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ref_on  <= 1'b1;
      nap_o   <= 1'b0;
      sleep_o <= 1'b0;
    end else begin
      ref_on  <= pwr_r != dasc_pkg::DASC_SLEEP;
      nap_o   <= pwr_r == dasc_pkg::DASC_NAP;
      sleep_o <= pwr_r == dasc_pkg::DASC_SLEEP;
    end
  end

  // lockout and frame edge counter
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lock_r <= 1'b0;
      edge_r <= dasc_pkg::CNT_RST;
    end else if (accept) begin
      lock_r <= 1'b1;
      edge_r <= dasc_pkg::CNT_RST;
    end else if (lock_r && sck_rise) begin
      edge_r <= edge_r + 6'h01;
      if (edge_r + 6'h01 == LOCK) begin
        lock_r <= 1'b0;
      end
    end
  end

  // sampled pairs queue; head is the word being shifted
  logic [dasc_pkg::WORD_W-1:0] smp, head;
  logic                        fin_rdy, fout_vld, pop;
  assign smp = {clamp(channel_zero_positive, channel_zero_neg),
                clamp(channel_one_positive, channel_one_neg)};

  dasc_fifo #(.WIDTH(dasc_pkg::WORD_W), .DEPTH(dasc_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n_r),
    .in_data   (smp),
    .in_valid  (accept),
    .in_ready  (fin_rdy),
    .out_data  (head),
    .out_valid (fout_vld),
    .out_ready (pop)
  );

  // frame done after the lockout edges; drain the sample
  assign pop = lock_r && sck_rise && (edge_r + 6'h01 == LOCK) && fout_vld;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      overflow_o <= 1'b0;
    end else if (accept && !fin_rdy) begin
      overflow_o <= 1'b1;
    end
  end

  // serial output, updated on each serial-clock rise
  logic [5:0] nxt_e;
  assign nxt_e = edge_r + 6'h01;
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sdo_o  <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (lock_r && sck_rise && fout_vld) begin
      if (nxt_e >= W0S && nxt_e < W0S + 6'(W)) begin
        sdo_oe <= 1'b1;
        sdo_o  <= head[dasc_pkg::WORD_W - 1 - int'(nxt_e - W0S)];
      end else if (nxt_e >= W1S && nxt_e < W1S + 6'(W)) begin
        sdo_oe <= 1'b1;
        sdo_o  <= head[W - 1 - int'(nxt_e - W1S)];
      end else begin
        sdo_oe <= 1'b0;
        sdo_o  <= 1'b0;
      end
    end else if (sck_rise) begin
      // frame over: release the line on the first rise after the lockout
      sdo_oe <= 1'b0;
      sdo_o  <= 1'b0;
    end
  end
endmodule

// [testbench/dasc_monitor.sv]
// dasc_monitor: concurrent checks on the converter control top ports
// assumes: bound to dasc_top; serial clock is slow against ref_clk
`timescale 1ns/1ps
module dasc_monitor (
  input wire logic ref_clk,          // clock
  input wire logic arst_n,           // reset, active low
  input wire logic serial_clk,       // serial clock pin
  input wire logic conversion_start, // start pin
  input wire logic sdo_o,            // serial data
  input wire logic sdo_oe,           // serial data enable
  input wire logic ref_on,           // reference powered
  input wire logic nap_o,            // nap state
  input wire logic sleep_o           // sleep state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence sck_quiet;
    $stable(serial_clk) [*6];
  endsequence
  sequence nap_ref;
    ##[0:1] (nap_o && ref_on);
  endsequence
  AST_NAP_REF: assert property (nap_o |-> ref_on) else $error("reference off in nap");
  AST_SLEEP_REF: assert property (sleep_o |-> !ref_on && !nap_o) else $error("sleep state wrong");
  AST_SLEEP_PATH: assert property ($rose(sleep_o) |-> $past(nap_o)) else $error("sleep not from nap");
  AST_NAP_CAUSE: assert property ($rose(nap_o) |-> $past(conversion_start, 4)) else $error("nap no start");
  AST_WAKE: assert property (nap_o && $rose(serial_clk) |-> ##[1:6] !nap_o) else $error("no wake");
  AST_SLEEP_EXIT: assert property ($fell(sleep_o) |-> nap_ref) else $error("sleep exit wrong");
  AST_SDO_HOLD: assert property (sck_quiet |=> $stable(sdo_oe) && $stable(sdo_o)) else $error("sdo moved");
  AST_NAP_STAYS: assert property (sck_quiet ##0 nap_o |=> nap_o || sleep_o) else $error("nap left");
endmodule
bind dasc_top dasc_monitor i_dasc_monitor (.ref_clk, .arst_n, .serial_clk, .conversion_start, .sdo_o, .sdo_oe,
  .ref_on, .nap_o, .sleep_o);

// [testbench/dasc_host.sv]
// dasc_host: host serial port model, drives serial clock and start, takes serial data
// assumes: 64 ns serial clock that runs only inside frames
`timescale 1ns/1ps
module dasc_host (
  output logic     serial_clk,       // serial clock to device
  output logic     conversion_start, // start and frame sync
  input wire logic sdo_o,            // serial data
  input wire logic sdo_oe            // serial data enable
);
  logic cap_q[$];
  initial begin
    serial_clk = 1'b0;
    conversion_start = 1'b0;
  end
  // start pulse one serial clock wide, clock held still
  task automatic pulse();
    #32 conversion_start = 1'b1;
    #64 conversion_start = 1'b0;
    #32;
  endtask
  // n rising edges; data taken on the falling edge, hi-z kept as z
  task automatic clocks(input int n);
    repeat (n) begin
      #32 serial_clk = 1'b1;
      #32 serial_clk = 1'b0;
      cap_q.push_back(sdo_oe ? sdo_o : 1'bz);
    end
  endtask
endmodule

// [testbench/dasc_tb_top.sv]
// dasc_tb_top: frames, lockout, nap and sleep sequencing against a per-frame code model
// assumes: dasc_host as far side, 200 MHz ref_clk
`timescale 1ns/1ps
module dasc_tb_top;
  logic                     ref_clk = 1'b0;
  logic                     arst_n = 1'b0;
  logic [dasc_pkg::RES_BITS:0] ch0;
  logic [dasc_pkg::RES_BITS:0] ch1;
  logic                     ch0_neg;
  logic                     ch1_neg;
  wire logic                serial_clk, conversion_start, sdo_o, sdo_oe, ref_on, nap_o, sleep_o, overflow_o;
  int                       n_errors = 0;
  int                       check_count = 0;
  int                       seed = 32'h664502A3;
  always #2.5 ref_clk = ~ref_clk;
  dasc_top i_dasc_top (.ref_clk, .arst_n, .serial_clk, .conversion_start, .channel_zero_positive(ch0),
    .channel_zero_neg(ch0_neg), .channel_one_positive(ch1), .channel_one_neg(ch1_neg), .sdo_o, .sdo_oe,
    .ref_on, .nap_o, .sleep_o, .overflow_o);
  dasc_host i_dasc_host (.serial_clk, .conversion_start, .sdo_o, .sdo_oe);
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [14:0] seen, input logic [14:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  function automatic int code(input int pos, input bit neg);
    if (neg) return 0;
    if (pos >= 16384) return 16383;
    return pos;
  endfunction
  task automatic st(input logic [2:0] e);
    repeat (8) @(posedge ref_clk);
    chk("power", {sleep_o, nap_o, ref_on}, e);
  endtask
  // one conversion; mid adds an ignored start and an input change inside the frame
  task automatic frame(input bit mid);
    int c0, c1;
    logic e;
    @(posedge ref_clk);
    ch0 <= 15'($random(seed));
    ch1 <= 15'($random(seed));
    ch0_neg <= 2'($random(seed)) == 2'h0;
    ch1_neg <= 2'($random(seed)) == 2'h0;
    @(posedge ref_clk);
    c0 = code(ch0, ch0_neg);
    c1 = code(ch1, ch1_neg);
    i_dasc_host.cap_q.delete();
    i_dasc_host.pulse();
    if (mid) begin
      i_dasc_host.clocks(5);
      @(posedge ref_clk);
      ch0 <= ~ch0;
      i_dasc_host.pulse();
    end
    i_dasc_host.clocks(mid ? 29 : 34);
    for (int i = 0; i < 34; i++) begin
      e = 1'bz;
      if (i >= 2 && i < 16) e = c0[15-i];
      if (i >= 18 && i < 32) e = c1[31-i];
      chk("sdo bit", 15'(i_dasc_host.cap_q[i]), 15'(e));
    end
  endtask
  initial begin
    #400000;
    n_errors++;
    close_out();
  end
  initial begin
    ch0 = 15'($random(seed));
    ch1 = 15'($random(seed));
    ch0_neg = 1'($random(seed));
    ch1_neg = 1'($random(seed));
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("sdo_oe", sdo_oe, 1'b0);
    st(3'b001);
    for (int k = 0; k < 6; k++) frame(k[0]);
    i_dasc_host.pulse();
    i_dasc_host.clocks(1);
    i_dasc_host.pulse();
    st(3'b001);
    i_dasc_host.clocks(33);
    i_dasc_host.pulse();
    i_dasc_host.pulse();
    st(3'b011);
    i_dasc_host.clocks(1);
    st(3'b001);
    i_dasc_host.clocks(32);
    frame(1'b0);
    repeat (5) i_dasc_host.pulse();
    st(3'b100);
    i_dasc_host.clocks(1);
    i_dasc_host.pulse();
    i_dasc_host.pulse();
    st(3'b011);
    i_dasc_host.clocks(33);
    st(3'b001);
    frame(1'b1);
    chk("overflow", overflow_o, 1'b0);
    close_out();
  end
endmodule
